/* File: hdl/scdsync_pkg.sv */
// Constants and types for the sample clock divider with sync realignment
// Notes on behaviour
// - The incoming clock is divided by any whole ratio from 1 to 8.
// - Falling-edge regeneration is on straight out of reset with no write needed.
// - Sync control bits 1 and 2 select realign on every sync pulse or only on the first after a write.
// - An accepted sync pulse returns the divider counter to its initial state.
// - With regeneration locked the internal clock is high for half the divided period, rounded up to whole input cycles.
// - Below the 40 MHz divided rate the regeneration loop is treated as dead.
// - While the loop is unlocked it is bypassed and the raw divider pulse shapes the clock.
// - Each sample is taken on the rising edge of the internal divided clock.
package scdsync_pkg;
  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [7:0] SYNC_CTRL_ADDR  = 8'h3a;
  localparam logic [7:0] DIV_CTRL_ADDR   = 8'h0b;
  localparam logic [7:0] REGEN_CTRL_ADDR = 8'h09;
  localparam int         SYNC_EN_BIT     = 1;
  localparam int         SYNC_ONCE_BIT   = 2;
  localparam int         REGEN_EN_BIT    = 0;
  localparam int         REGEN_LOCK_BIT  = 1;
  localparam logic [7:0] SYNC_CTRL_RST   = 8'h00;
  localparam logic [7:0] DIV_CTRL_RST    = 8'h00;
  localparam logic [7:0] REGEN_CTRL_RST  = 8'h01;

  // ---------------------------------------------------------------------------
  // Divider and loop timing
  // ---------------------------------------------------------------------------
  localparam int         DIV_MIN         = 1;
  localparam int         DIV_MAX         = 8;
  localparam int         CLK_MHZ         = 100;
  localparam int         CLK_PERIOD_NS   = 10;
  localparam int         REGEN_MIN_MHZ   = 40;
  localparam int         RELOCK_NS       = 1500;
  localparam int         RELOCK_CYC      = (RELOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] RELOCK_LAST     = 8'(RELOCK_CYC - 1);

  typedef enum logic [1:0] {LOCK_BYPASS, LOCK_ACQUIRE, LOCK_DONE} scdsync_lock_t;

  // Divide ratio from the three-bit field
  function automatic logic [3:0] scdsync_ratio(input logic [2:0] field);
    scdsync_ratio = {1'b0, field} + 4'h1;
  endfunction : scdsync_ratio
endpackage : scdsync_pkg

/* File: hdl/scdsync_top.sv */
// Sample clock divider with sync realignment and duty cycle regeneration
`timescale 1ns/1ns
module scdsync_top (
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_sync,
  input  wire logic       i_reg_wr,
  input  wire logic [7:0] i_reg_addr,
  input  wire logic [7:0] i_reg_wdata,
  output logic      [7:0] o_reg_rdata,
  output logic            o_smp_clk,
  output logic            o_sample_strobe,
  output logic            o_regen_locked
);
  import scdsync_pkg::*;

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  logic [2:0]    sync_q_r, sync_q_nxt;
  logic [7:0]    sync_ctrl_r, sync_ctrl_nxt;
  logic [7:0]    div_ctrl_r, div_ctrl_nxt;
  logic          regen_en_r, regen_en_nxt;
  logic          armed_r, armed_nxt;
  logic [3:0]    count_r, count_nxt;
  scdsync_lock_t lock_r, lock_nxt;
  logic [7:0]    lock_cnt_r, lock_cnt_nxt;
  logic [7:0]    rdata_nxt;
  logic          smp_clk_nxt;
  logic          strobe_nxt;
  logic          locked_nxt;
  logic [3:0]    ratio;
  logic [3:0]    high_len;
  logic          rate_ok;
  logic          sync_rise;
  logic          sync_accept;
  logic          wr_sync;
  logic          wr_div;

  // ---------------------------------------------------------------------------
  // Next values
  // ---------------------------------------------------------------------------
  always_comb begin
    ratio         = scdsync_ratio(div_ctrl_r[2:0]);
    rate_ok       = (int'(ratio) * REGEN_MIN_MHZ) <= CLK_MHZ;
    wr_sync       = i_reg_wr && (i_reg_addr == SYNC_CTRL_ADDR);
    wr_div        = i_reg_wr && (i_reg_addr == DIV_CTRL_ADDR);
    sync_q_nxt    = {sync_q_r[1:0], i_sync};
    sync_rise     = sync_q_r[1] && !sync_q_r[2];
    sync_accept   = sync_rise && sync_ctrl_r[SYNC_EN_BIT]
                    && (!sync_ctrl_r[SYNC_ONCE_BIT] || armed_r);
    sync_ctrl_nxt = wr_sync ? i_reg_wdata : sync_ctrl_r;
    div_ctrl_nxt  = wr_div ? {5'h00, i_reg_wdata[2:0]} : div_ctrl_r;
    regen_en_nxt  = (i_reg_wr && (i_reg_addr == REGEN_CTRL_ADDR))
                    ? i_reg_wdata[REGEN_EN_BIT] : regen_en_r;
    // One-shot arm: a write re-arms, the first accepted pulse disarms
    if (wr_sync) begin
      armed_nxt = 1'b1;
    end else if (sync_accept) begin
      armed_nxt = 1'b0;
    end else begin
      armed_nxt = armed_r;
    end
    // Divider counter
    if (sync_accept) begin
      count_nxt = 4'h0;
    end else if (count_r >= ratio - 4'h1) begin
      count_nxt = 4'h0;
    end else begin
      count_nxt = count_r + 4'h1;
    end
    // Regeneration loop
    lock_nxt     = lock_r;
    lock_cnt_nxt = lock_cnt_r;
    if (!regen_en_r || !rate_ok || (wr_div && i_reg_wdata[2:0] != div_ctrl_r[2:0])) begin
      lock_nxt     = LOCK_BYPASS;
      lock_cnt_nxt = 8'h00;
    end else begin
      case (lock_r)
        LOCK_BYPASS: begin
          lock_nxt     = LOCK_ACQUIRE;
          lock_cnt_nxt = 8'h00;
        end
        LOCK_ACQUIRE: begin
          if (lock_cnt_r == RELOCK_LAST) begin
            lock_nxt = LOCK_DONE;
          end else begin
            lock_cnt_nxt = lock_cnt_r + 8'h01;
          end
        end
        LOCK_DONE: lock_nxt = LOCK_DONE;
        default: lock_nxt = LOCK_BYPASS;
      endcase
    end
    high_len    = (lock_r == LOCK_DONE) ? 4'((ratio + 4'h1) >> 1) : 4'h1;
    smp_clk_nxt = count_nxt < high_len;
    strobe_nxt  = count_nxt == 4'h0;
    locked_nxt  = lock_nxt == LOCK_DONE;
    case (i_reg_addr)
      SYNC_CTRL_ADDR:  rdata_nxt = sync_ctrl_r;
      DIV_CTRL_ADDR:   rdata_nxt = div_ctrl_r;
      REGEN_CTRL_ADDR: rdata_nxt = {6'h00, lock_r == LOCK_DONE, regen_en_r};
      default:         rdata_nxt = 8'h00;
    endcase
  end

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      sync_q_r        <= 3'h0;
      sync_ctrl_r     <= SYNC_CTRL_RST;
      div_ctrl_r      <= DIV_CTRL_RST;
      regen_en_r      <= REGEN_CTRL_RST[REGEN_EN_BIT];
      armed_r         <= 1'b0;
      count_r         <= 4'h0;
      lock_r          <= LOCK_BYPASS;
      lock_cnt_r      <= 8'h00;
      o_reg_rdata     <= 8'h00;
      o_smp_clk       <= 1'b0;
      o_sample_strobe <= 1'b0;
      o_regen_locked  <= 1'b0;
    end else begin
      sync_q_r        <= sync_q_nxt;
      sync_ctrl_r     <= sync_ctrl_nxt;
      div_ctrl_r      <= div_ctrl_nxt;
      regen_en_r      <= regen_en_nxt;
      armed_r         <= armed_nxt;
      count_r         <= count_nxt;
      lock_r          <= lock_nxt;
      lock_cnt_r      <= lock_cnt_nxt;
      o_reg_rdata     <= rdata_nxt;
      o_smp_clk       <= smp_clk_nxt;
      o_sample_strobe <= strobe_nxt;
      o_regen_locked  <= locked_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  a_div_wrap: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (!sync_accept && count_r >= ratio - 4'h1) |=> (count_r == 4'h0 && o_sample_strobe))
    else $error("divider did not wrap at ratio");
  a_regen_default: assert property (@(posedge i_clk)
    !i_rst_n ##1 i_rst_n |-> regen_en_r)
    else $error("regeneration off after reset");
  a_once_disarm: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (sync_accept && !wr_sync) |=> !armed_r ##0 (!sync_ctrl_r[SYNC_ONCE_BIT] || !sync_accept))
    else $error("one-shot sync accepted twice");
  a_sync_realign: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    sync_accept |=> (count_r == 4'h0 && o_sample_strobe && o_smp_clk))
    else $error("sync did not reset divider");
  a_half_high: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (lock_r == LOCK_DONE && $stable(lock_r) && $stable(div_ctrl_r))
      |-> (o_smp_clk == ($past(count_nxt) < 4'((ratio + 4'h1) >> 1))))
    else $error("regenerated high time wrong");
  a_slow_bypass: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !rate_ok |=> (lock_r == LOCK_BYPASS && !o_regen_locked))
    else $error("loop active below minimum rate");
  a_lock_bypass: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (lock_r != LOCK_DONE) |=> (o_smp_clk == o_sample_strobe))
    else $error("unlocked clock not raw pulse");
  a_relock_time: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (lock_r == LOCK_BYPASS ##1 lock_r == LOCK_ACQUIRE) |-> !o_regen_locked [*8])
    else $error("locked too early");
  a_strobe_rise: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_sample_strobe |-> o_smp_clk)
    else $error("sample strobe off rising edge");
  a_sync_edge: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    sync_accept |-> ($past(i_sync, 2) && !$past(i_sync, 3)))
    else $error("sync accepted without rising edge");

  // ---------------------------------------------------------------------------
  // Checks on the divider and the sync path
  // ---------------------------------------------------------------------------
  a_div_step: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (!sync_accept && count_r < ratio - 4'h1) |=> (count_r == $past(count_r) + 4'h1))
    else $error("divider skipped a count");
  a_ratio_store: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    wr_div |=> (div_ctrl_r == {5'h00, $past(i_reg_wdata[2:0])}))
    else $error("divide ratio not stored");
  a_refused_sync: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (sync_rise && (!sync_ctrl_r[SYNC_EN_BIT] || (sync_ctrl_r[SYNC_ONCE_BIT] && !armed_r))
      && count_r < ratio - 4'h1) |=> (count_r != 4'h0))
    else $error("refused sync realigned the divider");
  a_arm_on_write: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    wr_sync |=> armed_r)
    else $error("sync control write did not arm");
  a_sync_single: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    sync_accept |=> !sync_accept)
    else $error("one sync edge accepted twice");
  a_strobe_start: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_sample_strobe |-> (count_r == 4'h0))
    else $error("sample strobe away from period start");
  a_clk_rise: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $rose(o_smp_clk) |-> o_sample_strobe)
    else $error("sample clock rose without strobe");

  // ---------------------------------------------------------------------------
  // Checks on the regeneration loop and its control
  // ---------------------------------------------------------------------------
  a_regen_store: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_reg_wr && i_reg_addr == REGEN_CTRL_ADDR) |=> (regen_en_r == $past(i_reg_wdata[REGEN_EN_BIT])))
    else $error("regeneration enable not stored");
  a_lock_flag: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_regen_locked == (lock_r == LOCK_DONE))
    else $error("lock flag differs from loop state");
  a_lock_stay: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (o_regen_locked && regen_en_r && rate_ok && !wr_div) |=> o_regen_locked)
    else $error("loop lost lock without cause");
  a_disable_drop: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_reg_wr && i_reg_addr == REGEN_CTRL_ADDR && !i_reg_wdata[REGEN_EN_BIT]) |-> ##2 !o_regen_locked)
    else $error("loop still locked after disable");
  a_ratio_drop: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (wr_div && i_reg_wdata[2:0] != div_ctrl_r[2:0]) |=> !o_regen_locked)
    else $error("loop still locked after ratio change");
  a_lock_count: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $rose(o_regen_locked) |-> (lock_cnt_r == RELOCK_LAST))
    else $error("loop locked before relock time");
  a_slow_unlocked: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (ratio > 4'h2) |-> !o_regen_locked)
    else $error("loop locked below minimum rate");
endmodule : scdsync_top

/* File: tb/scdsync_sync_src.sv */
// Sync pulse source standing in for the external sync generator
`timescale 1ns/1ns
module scdsync_sync_src (
  input  wire logic i_clk,
  input  wire logic i_go,
  output logic      o_sync
);
  logic go_seen;
  int   cnt = 0;
  initial o_sync = 1'b0;
  always @(posedge i_clk) begin
    go_seen = i_go;
    #1;
    if (go_seen && cnt == 0) cnt = 3;
    else if (cnt > 0) cnt--;
    o_sync = (cnt > 1);
  end
endmodule : scdsync_sync_src

/* File: tb/tb_top.sv */
// Self-checking bench for the sample clock divider
`timescale 1ns/1ns
module tb_top;
  import scdsync_pkg::*;
  logic       clk, rst_n, go, sync, wr, smp_clk, strobe, locked;
  logic [7:0] addr, wdata, rdata;
  int         mismatches, total_checks, per, hi;
  scdsync_sync_src u_src (.i_clk(clk), .i_go(go), .o_sync(sync));
  scdsync_top dut (.i_clk(clk), .i_rst_n(rst_n), .i_sync(sync), .i_reg_wr(wr), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_smp_clk(smp_clk), .o_sample_strobe(strobe),
    .o_regen_locked(locked));
  task check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task test_done;
    $display("Checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    tick(1);
    wr = 1'b0;
    tick(1);
  endtask : wr_reg
  task rd_chk(input logic [7:0] a, input logic [7:0] exp);
    addr = a;
    tick(2);
    check(rdata, exp);
  endtask : rd_chk
  task wait_strobe;
    for (int i = 0; i < 40; i++) begin
      if (strobe === 1'b1) return;
      tick(1);
    end
    mismatches++;
    test_done();
  endtask : wait_strobe
  task meas;
    wait_strobe();
    per = 0;
    hi = 0;
    do begin
      hi += int'(smp_clk);
      per++;
      tick(1);
    end while (strobe !== 1'b1 && per < 20);
  endtask : meas
  task t_reset;
    rd_chk(SYNC_CTRL_ADDR, 8'h00);
    rd_chk(DIV_CTRL_ADDR, 8'h00);
    rd_chk(REGEN_CTRL_ADDR, 8'h01);
    rd_chk(8'h55, 8'h00);
  endtask : t_reset
  task t_ratio;
    for (int r = 1; r <= 8; r++) begin
      wr_reg(DIV_CTRL_ADDR, 8'(r - 1));
      meas();
      meas();
      check(8'(per), 8'(r));
      check(8'(hi), 8'h01);
    end
    check(8'(locked), 8'h00);
  endtask : t_ratio
  task t_lock;
    wr_reg(DIV_CTRL_ADDR, 8'h01);
    tick(100);
    check(8'(locked), 8'h00);
    tick(60);
    check(8'(locked), 8'h01);
    meas();
    meas();
    check(8'(per), 8'h02);
    check(8'(hi), 8'h01);
    rd_chk(REGEN_CTRL_ADDR, 8'h03);
    wr_reg(DIV_CTRL_ADDR, 8'h02);
    check(8'(locked), 8'h00);
  endtask : t_lock
  task t_sync(input logic [7:0] mode, input logic e1, input logic e2);
    wr_reg(DIV_CTRL_ADDR, 8'h07);
    wr_reg(SYNC_CTRL_ADDR, mode);
    for (int k = 0; k < 2; k++) begin
      wait_strobe();
      go = 1'b1;
      tick(1);
      go = 1'b0;
      tick(3);
      check(8'(strobe), 8'(k == 0 ? e1 : e2));
    end
  endtask : t_sync
  task t_regen;
    wr_reg(DIV_CTRL_ADDR, 8'h01);
    tick(160);
    check(8'(locked), 8'h01);
    wr_reg(REGEN_CTRL_ADDR, 8'h00);
    check(8'(locked), 8'h00);
    rd_chk(REGEN_CTRL_ADDR, 8'h00);
    wr_reg(DIV_CTRL_ADDR, 8'h00);
    tick(160);
    check(8'(locked), 8'h00);
    meas();
    meas();
    check(8'(per), 8'h01);
    check(8'(hi), 8'h01);
    rst_n = 1'b0;
    tick(2);
    rst_n = 1'b1;
    rd_chk(REGEN_CTRL_ADDR, 8'h01);
    tick(160);
    check(8'(locked), 8'h01);
  endtask : t_regen
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    {rst_n, wr, go, addr, wdata} = '0;
    mismatches = 0;
    total_checks = 0;
    repeat (16) @(posedge clk);
    #1;
    rst_n = 1'b1;
    t_reset();
    t_ratio();
    t_lock();
    t_regen();
    t_sync(8'h00, 1'b0, 1'b0);
    t_sync(8'h04, 1'b0, 1'b0);
    t_sync(8'h02, 1'b1, 1'b1);
    t_sync(8'h06, 1'b1, 1'b0);
    test_done();
  end
endmodule : tb_top
